// ==== tdc_write_control_regs_bench.sv ====
`timescale 1ns/1ns
module tdc_write_control_regs_bench;
  import tdcw_pkg::*;
  logic i_clk, i_rst_b, i_wr, i_rd, i_alu_done;
  logic [3:0] i_addr, o_upper_hit_selector, o_lower_hit_selector;
  logic [7:0] i_wdata, o_rdata, o_loop_factor, rd;
  logic o_cal_run_pulse, o_cal_req, o_alu_scale_request, o_predivided_range_select;
  logic o_auto_cal_en, o_second_stop_polarity, o_first_stop_polarity, o_start_input_polarity;
  logic o_lsb_tuning_mode, o_high_res_mode, o_loop_phase_invert, o_loop_track_mode;
  logic o_single_port_en, o_cap_measure;
  logic [5:0] o_fine_delay_trim;
  logic [2:0] o_time_unit_ref_divider, o_loop_ref_divider;
  logic [2:0] o_port_count_or_index, o_impedance_unit_divider;
  tdcw_src_type o_upper_src, o_lower_src;
  logic [7:0] sh [6];
  logic [11:0] tbl [13];
  int n_errors, n_tests, cnt;
  wire [46:0] fields = {o_cal_req, o_alu_scale_request, o_predivided_range_select,
    o_auto_cal_en, o_second_stop_polarity, o_first_stop_polarity, o_start_input_polarity,
    o_lsb_tuning_mode, o_high_res_mode, o_fine_delay_trim, o_upper_hit_selector,
    o_lower_hit_selector, o_loop_factor, o_time_unit_ref_divider, o_loop_phase_invert,
    o_loop_track_mode, o_loop_ref_divider, o_port_count_or_index, o_single_port_en,
    o_cap_measure, o_impedance_unit_divider};

  tdcw_host host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  tdcw_regs dut (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .i_alu_done, .o_rdata,
    .o_cal_run_pulse, .o_cal_req, .o_alu_scale_request, .o_predivided_range_select,
    .o_auto_cal_en, .o_second_stop_polarity, .o_first_stop_polarity, .o_start_input_polarity,
    .o_lsb_tuning_mode, .o_high_res_mode, .o_fine_delay_trim, .o_upper_hit_selector,
    .o_lower_hit_selector, .o_upper_src, .o_lower_src, .o_loop_factor,
    .o_time_unit_ref_divider, .o_loop_phase_invert, .o_loop_track_mode, .o_loop_ref_divider,
    .o_port_count_or_index, .o_single_port_en, .o_cap_measure, .o_impedance_unit_divider);

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic tdcw_src_type src_of(input logic [3:0] n);
    if (n == 4'h0)
      return TDCW_SRC_START;
    if (n[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4})
      return TDCW_SRC_HIT;
    if (n[2:0] >= 3'h6)
      return TDCW_SRC_CAL;
    return TDCW_SRC_NONE;
  endfunction
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    host.wr_reg(a, d);
    if (a < 4'h6)
      sh[a] = d;
    repeat (3) @(posedge i_clk);
    #1;
    check("fields", fields, {sh[0][6:0], sh[1], sh[2], sh[3], sh[4], sh[5]});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    i_rst_b = 1'b0;
    i_alu_done = 1'b0;
    foreach (sh[i]) sh[i] = 8'h00;
    // host programs trim 0x0d; addresses 7 and f unmapped
    tbl = '{12'h07f, 12'h18d, 12'h14d, 12'h3a5, 12'h35a, 12'h4b6, 12'h449, 12'h5f2,
      12'h50d, 12'h2c3, 12'h7ff, 12'hfff, 12'h000};
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    check("reset fields", fields, 64'h0);
    $display("test reset done");
    foreach (tbl[i]) put(tbl[i][11:8], tbl[i][7:0]);
    $display("test fields done");
    for (int n = 0; n < 16; n++)
    begin
      put(4'h2, {n[3:0], ~n[3:0]});
      check("upper src", o_upper_src, src_of(n[3:0]));
      check("lower src", o_lower_src, src_of(~n[3:0]));
    end
    $display("test hit selectors done");
    foreach (tbl[i])
    begin
      if (i < 2)
      begin
        put(4'h0, i ? 8'h40 : 8'h20);
        host.rd_reg(4'h9, rd);
        check("status", rd, i ? 8'h08 : 8'h10);
        @(posedge i_clk);
        i_alu_done <= 1'b1;
        @(posedge i_clk);
        i_alu_done <= 1'b0;
        sh[0] = 8'h00;
        put(4'hc, 8'hff);
        host.rd_reg(4'h9, rd);
        check("status cleared", rd, 8'h00);
      end
    end
    host.rd_reg(4'h5, rd);
    check("write only read", rd, 8'h00);
    $display("test requests done");
    host.wr_reg(4'h0, 8'h80);
    cnt = 0;
    repeat (4)
    begin
      #1;
      if (o_cal_run_pulse === 1'b1)
        cnt++;
      @(posedge i_clk);
    end
    check("cal run pulses", cnt, 1);
    $display("test cal run done");
    give_verdict();
  end
endmodule

// ==== tdcw_host.sv ====
`timescale 1ns/1ns
module tdcw_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial
  begin
    o_addr = 4'hf;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    // idle bus shows inverted values, never stale ones
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule

// ==== tdcw_map.svh ====
// Operation
// - bit7 reg0 launches reference calibration run
// - bit6 reg0 requests calibration computation
// - bit5 reg0 requests multiplication
// - bit4 reg0 selects predivided range
// - bit3 reg0 enables auto calibration
// - bits2..0 reg0 edge polarity, 0 rise
// - bit7 reg1 selects lsb tuning mode
// - bit6 reg1 selects high resolution
// - reg2 two nibble hit selectors
// - zero nibble start, codes 1-4 hits
// - codes 6,7 select calibration values
// - reg3 holds 8-bit loop factor
// - reg4 bits7..5 time unit divider
// - reg4 bit4 inverts loop phase
// - reg4 bit3 loop track mode
// - reg4 bits2..0 loop reference divider
// - reg5 bits7..5 port count or index
// - reg5 bit4 single port select
// - reg5 bit3 capacitor measurement
// - reg5 bits2..0 impedance unit divider
// - request bits mirrored in status bits4,3
`ifndef TDCW_MAP_SVH
`define TDCW_MAP_SVH
`define TDCW_OFS_CMD 4'h0
`define TDCW_OFS_RES 4'h1
`define TDCW_OFS_HIT 4'h2
`define TDCW_OFS_PLL 4'h3
`define TDCW_OFS_DIV 4'h4
`define TDCW_OFS_RLC 4'h5
`define TDCW_OFS_STAT2 4'h9
`define TDCW_RST_BYTE 8'h00
`define TDCW_BIT_CAL_RUN 7
`define TDCW_BIT_CAL_REQ 6
`define TDCW_BIT_MUL_REQ 5
`define TDCW_BIT_RANGE 4
`define TDCW_BIT_AUTO 3
`define TDCW_BIT_STAT_MUL 4
`define TDCW_BIT_STAT_CAL 3
`define TDCW_HIT_START 4'h0
`define TDCW_CODE_CAL1 3'h6
`define TDCW_CODE_CAL2 3'h7
`define TDCW_CODE_HIT4 3'h4
`endif

// ==== tdcw_pkg.sv ====
package tdcw_pkg;
  typedef enum logic [1:0] {TDCW_SRC_START, TDCW_SRC_HIT, TDCW_SRC_CAL, TDCW_SRC_NONE}
    tdcw_src_type;
endpackage

// ==== tdcw_regs.sv ====
`timescale 1ns/1ns
`include "tdcw_map.svh"
module tdcw_regs #(
  parameter int ADDR_W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_alu_done,
  output logic [7:0] o_rdata,
  output logic o_cal_run_pulse,
  output logic o_cal_req,
  output logic o_alu_scale_request,
  output logic o_predivided_range_select,
  output logic o_auto_cal_en,
  output logic o_second_stop_polarity,
  output logic o_first_stop_polarity,
  output logic o_start_input_polarity,
  output logic o_lsb_tuning_mode,
  output logic o_high_res_mode,
  output logic [5:0] o_fine_delay_trim,
  output logic [3:0] o_upper_hit_selector,
  output logic [3:0] o_lower_hit_selector,
  output tdcw_pkg::tdcw_src_type o_upper_src,
  output tdcw_pkg::tdcw_src_type o_lower_src,
  output logic [7:0] o_loop_factor,
  output logic [2:0] o_time_unit_ref_divider,
  output logic o_loop_phase_invert,
  output logic o_loop_track_mode,
  output logic [2:0] o_loop_ref_divider,
  output logic [2:0] o_port_count_or_index,
  output logic o_single_port_en,
  output logic o_cap_measure,
  output logic [2:0] o_impedance_unit_divider
);
  import tdcw_pkg::*;

  initial
  begin
    if (ADDR_W < 4)
      $error("ADDR_W too small for the register map");
  end

  logic [7:0] cmd_r;
  logic [7:0] res_r;
  logic [7:0] hit_r;
  logic [7:0] pll_r;
  logic [7:0] div_r;
  logic [7:0] rlc_r;
  logic [7:0] rdata_nxt;
  logic [7:0] stat2_nxt;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // decodes a selector nibble into a source class
  function automatic tdcw_src_type decode_sel(input logic [3:0] n);
    if (n == `TDCW_HIT_START)
      decode_sel = TDCW_SRC_START;
    else if (n[2:0] == `TDCW_CODE_CAL1 || n[2:0] == `TDCW_CODE_CAL2)
      decode_sel = TDCW_SRC_CAL;
    else if (n[2:0] != 3'h0 && n[2:0] <= `TDCW_CODE_HIT4)
      decode_sel = TDCW_SRC_HIT;
    else
      decode_sel = TDCW_SRC_NONE;
  endfunction

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cmd_r <= `TDCW_RST_BYTE;
    else if (i_wr && hit(i_addr, `TDCW_OFS_CMD))
      cmd_r <= i_wdata;
    else if (i_alu_done)
    begin
      // alu completion retires the requests; a write in the same cycle wins
      cmd_r[`TDCW_BIT_CAL_REQ] <= 1'b0;
      cmd_r[`TDCW_BIT_MUL_REQ] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_cal_run_pulse <= 1'b0;
    else
      o_cal_run_pulse <= i_wr && hit(i_addr, `TDCW_OFS_CMD) && i_wdata[`TDCW_BIT_CAL_RUN];
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      res_r <= `TDCW_RST_BYTE;
      hit_r <= `TDCW_RST_BYTE;
      pll_r <= `TDCW_RST_BYTE;
      div_r <= `TDCW_RST_BYTE;
      rlc_r <= `TDCW_RST_BYTE;
    end
    else if (i_wr)
    begin
      if (hit(i_addr, `TDCW_OFS_RES))
        res_r <= i_wdata;
      if (hit(i_addr, `TDCW_OFS_HIT))
        hit_r <= i_wdata;
      if (hit(i_addr, `TDCW_OFS_PLL))
        pll_r <= i_wdata;
      if (hit(i_addr, `TDCW_OFS_DIV))
        div_r <= i_wdata;
      if (hit(i_addr, `TDCW_OFS_RLC))
        rlc_r <= i_wdata;
    end
  end

  always_comb
  begin
    stat2_nxt = 8'h00;
    stat2_nxt[`TDCW_BIT_STAT_MUL] = cmd_r[`TDCW_BIT_MUL_REQ];
    stat2_nxt[`TDCW_BIT_STAT_CAL] = cmd_r[`TDCW_BIT_CAL_REQ];
    // control registers are write only and read back as zero
    rdata_nxt = 8'h00;
    if (i_rd && hit(i_addr, `TDCW_OFS_STAT2))
      rdata_nxt = stat2_nxt;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rdata <= 8'h00;
    else
      o_rdata <= rdata_nxt;
  end

  // registered field outputs, one cycle behind the stored bytes
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_cal_req <= 1'b0;
      o_alu_scale_request <= 1'b0;
      o_predivided_range_select <= 1'b0;
      o_auto_cal_en <= 1'b0;
      o_second_stop_polarity <= 1'b0;
      o_first_stop_polarity <= 1'b0;
      o_start_input_polarity <= 1'b0;
      o_lsb_tuning_mode <= 1'b0;
      o_high_res_mode <= 1'b0;
      o_fine_delay_trim <= 6'h00;
      o_upper_hit_selector <= 4'h0;
      o_lower_hit_selector <= 4'h0;
      o_upper_src <= TDCW_SRC_START;
      o_lower_src <= TDCW_SRC_START;
      o_loop_factor <= 8'h00;
      o_time_unit_ref_divider <= 3'h0;
      o_loop_phase_invert <= 1'b0;
      o_loop_track_mode <= 1'b0;
      o_loop_ref_divider <= 3'h0;
      o_port_count_or_index <= 3'h0;
      o_single_port_en <= 1'b0;
      o_cap_measure <= 1'b0;
      o_impedance_unit_divider <= 3'h0;
    end
    else
    begin
      o_cal_req <= cmd_r[`TDCW_BIT_CAL_REQ];
      o_alu_scale_request <= cmd_r[`TDCW_BIT_MUL_REQ];
      o_predivided_range_select <= cmd_r[`TDCW_BIT_RANGE];
      o_auto_cal_en <= cmd_r[`TDCW_BIT_AUTO];
      o_second_stop_polarity <= cmd_r[2];
      o_first_stop_polarity <= cmd_r[1];
      o_start_input_polarity <= cmd_r[0];
      o_lsb_tuning_mode <= res_r[7];
      o_high_res_mode <= res_r[6];
      o_fine_delay_trim <= res_r[5:0];
      o_upper_hit_selector <= hit_r[7:4];
      o_lower_hit_selector <= hit_r[3:0];
      o_upper_src <= decode_sel(hit_r[7:4]);
      o_lower_src <= decode_sel(hit_r[3:0]);
      o_loop_factor <= pll_r;
      o_time_unit_ref_divider <= div_r[7:5];
      o_loop_phase_invert <= div_r[4];
      o_loop_track_mode <= div_r[3];
      o_loop_ref_divider <= div_r[2:0];
      o_port_count_or_index <= rlc_r[7:5];
      o_single_port_en <= rlc_r[4];
      o_cap_measure <= rlc_r[3];
      o_impedance_unit_divider <= rlc_r[2:0];
    end
  end

  a_cal_run_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == ADDR_W'(`TDCW_OFS_CMD) && i_wdata[7]) |=> o_cal_run_pulse)
    else $error("calibration run not launched");
  a_mul_request: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == ADDR_W'(`TDCW_OFS_CMD)) |=> ##1 (o_alu_scale_request == $past(i_wdata[5], 2)))
    else $error("multiply request wrong");
  a_cal_request: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == ADDR_W'(`TDCW_OFS_CMD)) |=> ##1 (o_cal_req == $past(i_wdata[6], 2)))
    else $error("calibration request wrong");
  a_edge_polarity: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == ADDR_W'(`TDCW_OFS_CMD)) |=> ##1
    ({o_second_stop_polarity, o_first_stop_polarity, o_start_input_polarity}
      == $past(i_wdata[2:0], 2)))
    else $error("edge polarity wrong");
  a_loop_factor: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == ADDR_W'(`TDCW_OFS_PLL)) |=> ##1 (o_loop_factor == $past(i_wdata, 2)))
    else $error("loop factor wrong");
  a_start_select: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == ADDR_W'(`TDCW_OFS_HIT) && i_wdata[3:0] == 4'h0) |=> ##1
    (o_lower_src == TDCW_SRC_START))
    else $error("start not selected");
  a_cal_select: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == ADDR_W'(`TDCW_OFS_HIT) && i_wdata[6:5] == 2'b11) |=> ##1
    (o_upper_src == TDCW_SRC_CAL))
    else $error("calibration value not selected");
  a_dividers: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == ADDR_W'(`TDCW_OFS_DIV)) |=> ##1
    ({o_time_unit_ref_divider, o_loop_ref_divider} == {$past(i_wdata[7:5], 2), $past(i_wdata[2:0], 2)}))
    else $error("divider select wrong");
  a_status_mirror: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_rd && i_addr == ADDR_W'(`TDCW_OFS_STAT2)) |=> (o_rdata[4:3] == $past(cmd_r[6:5])
      ? o_rdata[4:3] == {$past(cmd_r[5]), $past(cmd_r[6])} : 1'b1) && o_rdata[4] == $past(cmd_r[5]))
    else $error("status mirror wrong");
  a_hold_fields: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !(i_wr && i_addr == ADDR_W'(`TDCW_OFS_RLC)) |=> ##1 $stable(o_port_count_or_index))
    else $error("field changed without write");
endmodule
